// File: sfc_pkg.sv
/*
 pkg for serial frame check: framing codes, crc constants, gap timing.
 assumes a 10 MHz system clock.
*/
package sfc_pkg;
	localparam logic [7:0] COLON_CODE = 8'h3a;
	localparam logic [7:0] CR_CODE = 8'h0d;
	localparam logic [7:0] LF_CODE = 8'h0a;
	localparam logic [15:0] CRC_PRESET = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [3:0] CRC_STEPS = 4'h8;
	localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
	localparam logic [7:0] MAX_WRITE_WORDS = 8'h0a;
	// word count low byte position; shortest binary frame is address, function, two check bytes
	localparam logic [7:0] COUNT_LOW_IDX = 8'h05;
	localparam logic [7:0] MIN_BIN_BYTES = 8'h04;
	localparam int CLK_HZ = 10000000;
	localparam int GAP_MS = 10;
	// least time: more than 10 ms, so one cycle beyond the figure
	localparam int GAP_CYCLES = (CLK_HZ / 1000) * GAP_MS + 1;
	localparam int GAP_W = 20;
	localparam int FRAME_MAX = 64;
	typedef enum logic [1:0] {SFC_IDLE, SFC_BODY, SFC_HIGH, SFC_LF} sfc_state_t;
endpackage

// File: sfc_crc_if.sv
/*
 interface between frame checker and crc engine.
 assumes one clock domain.
*/
`timescale 1ns/1ps
interface sfc_crc_if;
	logic clear;
	logic byte_valid;
	logic [7:0] data;
	logic busy;
	logic [15:0] crc;
	modport ctrl (output clear, output byte_valid, output data, input busy, input crc);
	modport eng (input clear, input byte_valid, input data, output busy, output crc);
endinterface

// File: sfc_crc_engine.sv
/*
 bit-serial crc engine, one shift per clock, eight per byte.
 assumes the controller offers a byte only while busy is low.
*/
`timescale 1ns/1ps
module sfc_crc_engine (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	sfc_crc_if.eng bus
);
	logic [15:0] crc_reg;
	logic [15:0] crc_next;
	logic [3:0] step_reg;
	logic [15:0] shifted;

	assign shifted = {1'b0, crc_reg[15:1]} ^ (crc_reg[0] ? sfc_pkg::CRC_POLY : 16'h0000);
	assign bus.busy = (step_reg != 4'h0);
	assign bus.crc = crc_reg;

	always_comb
	begin
		crc_next = crc_reg;
		if (bus.clear)
			crc_next = sfc_pkg::CRC_PRESET;
		else if (bus.byte_valid && !bus.busy)
			crc_next = {crc_reg[15:8], crc_reg[7:0] ^ bus.data};
		else if (bus.busy)
			crc_next = shifted;
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			crc_reg <= sfc_pkg::CRC_PRESET;
			step_reg <= 4'h0;
		end
		else
		begin
			crc_reg <= crc_next;
			if (bus.clear)
				step_reg <= 4'h0;
			else if (bus.byte_valid && !bus.busy)
				step_reg <= sfc_pkg::CRC_STEPS;
			else if (bus.busy)
				step_reg <= step_reg - 4'h1;
		end
	end

	eight_steps_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(bus.byte_valid && !bus.busy && !bus.clear) |=> bus.busy [*8] ##1 !bus.busy)
		else $error("crc engine did not take eight shifts");
	preset_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		bus.clear |=> (crc_reg == sfc_pkg::CRC_PRESET))
		else $error("crc not preset after clear");
	shift_poly_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(bus.busy && !bus.clear) |=> crc_reg == ({1'b0, $past(crc_reg[15:1])}
		^ ($past(crc_reg[0]) ? sfc_pkg::CRC_POLY : 16'h0000)))
		else $error("crc shift step wrong");
endmodule

// File: sfc_frame_check.sv
/*
 receive frame checker for ascii (lrc) and binary (crc) framing.
 assumes bytes arrive one at a time from a uart, synchronous to i_clk_sys.
*/
`timescale 1ns/1ps
module sfc_frame_check #(
	// silent-gap length in clocks; only a bench shortens it to keep runs brief
	parameter int GAP_CYCLES = sfc_pkg::GAP_CYCLES
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_ascii_mode,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_data,
	output logic o_rx_done,
	output logic o_frame_ok,
	output logic o_check_err,
	output logic [7:0] o_station,
	output logic [7:0] o_function,
	output logic o_too_many_words
);
	// ==========================================
	// helpers
	function automatic logic [3:0] hex_val(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39)
			return 4'(c - 8'h30);
		else if (c >= 8'h41 && c <= 8'h46)
			return 4'(c - 8'h37);
		else
			return 4'(c - 8'h57);
	endfunction

	function automatic logic is_hex(input logic [7:0] c);
		return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46)
			|| (c >= 8'h61 && c <= 8'h66);
	endfunction

	// ==========================================
	// state
	sfc_crc_if crc_bus ();
	sfc_pkg::sfc_state_t state_reg;
	logic [7:0] sum_reg;
	logic [3:0] nib_reg;
	logic [7:0] cnt_reg;
	logic [7:0] b_prev_reg;
	logic [7:0] b_prev2_reg;
	logic [15:0] crc_hist0_reg;
	logic [15:0] crc_hist1_reg;
	logic [sfc_pkg::GAP_W-1:0] gap_reg;
	logic pend_reg;
	logic [7:0] pend_byte_reg;
	logic bad_reg;
	logic done_reg;
	logic ok_reg;
	logic err_reg;
	logic [7:0] station_reg;
	logic [7:0] func_reg;
	logic many_reg;

	sfc_crc_engine u_crc (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.bus(crc_bus)
	);

	// ==========================================
	// decode
	wire gap_hit = (gap_reg == sfc_pkg::GAP_W'(GAP_CYCLES));
	wire bin_byte = !i_ascii_mode && i_rx_valid;
	wire bin_start = bin_byte && gap_hit;
	wire is_colon = i_rx_data == sfc_pkg::COLON_CODE;
	wire asc_hex = i_ascii_mode && i_rx_valid && is_hex(i_rx_data);
	wire [7:0] asc_byte = {nib_reg, hex_val(i_rx_data)};
	wire asc_pair = asc_hex && state_reg == sfc_pkg::SFC_HIGH;
	// decoded byte whose lrc is zero only when covered bytes plus check sum to zero
	wire [7:0] sum_with = sum_reg + asc_byte;
	// binary end: crc over all but the last two bytes, checked low byte first
	wire [15:0] rx_crc = {b_prev_reg, b_prev2_reg};
	wire bin_end = !i_ascii_mode && state_reg == sfc_pkg::SFC_BODY && gap_hit
		&& !crc_bus.busy && !pend_reg;
	wire bin_good = cnt_reg >= sfc_pkg::MIN_BIN_BYTES && crc_hist1_reg == rx_crc && !bad_reg;
	wire asc_end = i_ascii_mode && i_rx_valid && state_reg == sfc_pkg::SFC_LF;
	wire asc_good = i_rx_data == sfc_pkg::LF_CODE && sum_reg == 8'h00 && !bad_reg;
	// write-multiple word count low half is byte index 5 of the frame
	wire [7:0] cur_byte = i_ascii_mode ? asc_byte : i_rx_data;
	wire cur_take = i_ascii_mode ? asc_pair : (bin_byte && state_reg == sfc_pkg::SFC_BODY);
	wire many_now = cur_take && cnt_reg == sfc_pkg::COUNT_LOW_IDX
		&& func_reg == sfc_pkg::FC_WRITE_MULTI
		&& cur_byte > sfc_pkg::MAX_WRITE_WORDS;

	assign crc_bus.clear = bin_start;
	assign crc_bus.byte_valid = pend_reg && !crc_bus.busy;
	assign crc_bus.data = pend_byte_reg;

	// ==========================================
	// sequencing
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_reg <= sfc_pkg::SFC_IDLE;
			gap_reg <= '0;
			sum_reg <= 8'h00;
			nib_reg <= 4'h0;
			cnt_reg <= 8'h00;
			b_prev_reg <= 8'h00;
			b_prev2_reg <= 8'h00;
			crc_hist0_reg <= sfc_pkg::CRC_PRESET;
			crc_hist1_reg <= sfc_pkg::CRC_PRESET;
			pend_reg <= 1'b0;
			pend_byte_reg <= 8'h00;
			bad_reg <= 1'b0;
			done_reg <= 1'b0;
			ok_reg <= 1'b0;
			err_reg <= 1'b0;
			station_reg <= 8'h00;
			func_reg <= 8'h00;
			many_reg <= 1'b0;
		end
		else
		begin
			done_reg <= i_rx_valid;
			ok_reg <= 1'b0;
			err_reg <= 1'b0;
			if (i_rx_valid)
				gap_reg <= '0;
			else if (!gap_hit)
				gap_reg <= gap_reg + 1'b1;
			if (crc_bus.byte_valid)
				pend_reg <= 1'b0;
			if (many_now)
				bad_reg <= 1'b1;
			if (cur_take)
			begin
				cnt_reg <= cnt_reg + 8'h01;
				if (cnt_reg == 8'h00)
					station_reg <= cur_byte;
				if (cnt_reg == 8'h01)
					func_reg <= cur_byte;
			end
			if (bin_start)
			begin
				state_reg <= sfc_pkg::SFC_BODY;
				cnt_reg <= 8'h01;
				station_reg <= i_rx_data;
				bad_reg <= 1'b0;
				many_reg <= 1'b0;
				b_prev_reg <= i_rx_data;
				pend_reg <= 1'b1;
				pend_byte_reg <= i_rx_data;
			end
			else if (bin_byte && state_reg == sfc_pkg::SFC_BODY)
			begin
				b_prev2_reg <= b_prev_reg;
				b_prev_reg <= i_rx_data;
				// crc lags two bytes so the trailing check field is excluded
				crc_hist1_reg <= crc_hist0_reg;
				crc_hist0_reg <= crc_bus.crc;
				if (pend_reg || crc_bus.busy)
					bad_reg <= 1'b1;
				pend_reg <= 1'b1;
				pend_byte_reg <= i_rx_data;
			end
			else if (bin_end)
			begin
				state_reg <= sfc_pkg::SFC_IDLE;
				ok_reg <= bin_good;
				err_reg <= !bin_good;
				many_reg <= bad_reg;
			end
			if (i_ascii_mode && i_rx_valid)
			begin
				if (is_colon)
				begin
					state_reg <= sfc_pkg::SFC_BODY;
					sum_reg <= 8'h00;
					cnt_reg <= 8'h00;
					bad_reg <= 1'b0;
					many_reg <= 1'b0;
				end
				else if (asc_end)
				begin
					state_reg <= sfc_pkg::SFC_IDLE;
					ok_reg <= asc_good;
					err_reg <= !asc_good;
					many_reg <= bad_reg;
				end
				else if (state_reg == sfc_pkg::SFC_BODY && asc_hex)
				begin
					nib_reg <= hex_val(i_rx_data);
					state_reg <= sfc_pkg::SFC_HIGH;
				end
				else if (asc_pair)
				begin
					sum_reg <= sum_with;
					state_reg <= sfc_pkg::SFC_BODY;
				end
				else if (state_reg == sfc_pkg::SFC_BODY && i_rx_data == sfc_pkg::CR_CODE)
					state_reg <= sfc_pkg::SFC_LF;
				else if (state_reg != sfc_pkg::SFC_IDLE)
					bad_reg <= 1'b1;
			end
		end
	end

	assign o_rx_done = done_reg;
	assign o_frame_ok = ok_reg;
	assign o_check_err = err_reg;
	assign o_station = station_reg;
	assign o_function = func_reg;
	assign o_too_many_words = many_reg;

	// ==========================================
	// checks
	mode_select_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_ascii_mode && i_rx_valid && state_reg == sfc_pkg::SFC_LF && !is_colon)
		|=> (o_frame_ok != o_check_err) && !crc_bus.busy)
		else $error("ascii end did not report a verdict");
	done_pulse_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_rx_valid |=> o_rx_done)
		else $error("no done after byte");
	verdict_excl_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!(o_frame_ok && o_check_err))
		else $error("frame both good and bad");
	lrc_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		o_frame_ok && $past(i_ascii_mode) |-> $past(sum_reg) == 8'h00)
		else $error("ascii frame accepted with nonzero sum");
	gap_start_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		crc_bus.clear |-> !$past(i_rx_valid) && gap_reg == sfc_pkg::GAP_W'(GAP_CYCLES))
		else $error("binary frame began without silent gap");
	crc_order_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(o_frame_ok && !$past(i_ascii_mode)) |-> $past(crc_hist1_reg)
		== {$past(b_prev_reg), $past(b_prev2_reg)})
		else $error("crc accepted in wrong byte order");
endmodule

// File: sfc_master_model.sv
/*
 serial master stand-in: hands received bytes to the checker as one-cycle strobes.
 assumes the checker samples on the rising edge of i_clk_sys.
*/
`timescale 1ns/1ps
module sfc_master_model (
	input wire logic i_clk_sys,
	output logic o_rx_valid,
	output logic [7:0] o_rx_data
);
	int n_sent = 0;
	initial
	begin
		o_rx_valid = 1'b0;
		o_rx_data = 8'h00;
	end
	// ====================
	// byte and frame tasks
	// idle data shows the inverse of the last byte, never a held copy
	task automatic send(input logic [7:0] b, input int gap);
		@(posedge i_clk_sys);
		o_rx_valid <= 1'b1;
		o_rx_data <= b;
		n_sent++;
		@(posedge i_clk_sys);
		o_rx_valid <= 1'b0;
		o_rx_data <= ~b;
		repeat (gap) @(posedge i_clk_sys);
	endtask
	function automatic logic [7:0] hex(input logic [3:0] n);
		return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
	endfunction
	task automatic send_ascii(input logic [7:0] b[$]);
		send(sfc_pkg::COLON_CODE, 1);
		foreach (b[i])
		begin
			send(hex(b[i][7:4]), 1);
			send(hex(b[i][3:0]), 1);
		end
		send(sfc_pkg::CR_CODE, 1);
		// no tail gap: the verdict pulse stands one edge after the lf
		send(sfc_pkg::LF_CODE, 0);
	endtask
	// eight idle cycles keep bytes ten cycles apart for the shifter
	task automatic send_rtu(input logic [7:0] b[$]);
		foreach (b[i])
			send(b[i], 8);
	endtask
endmodule

// File: serial_frame_check_lrc_crc_tb.sv
/*
 self-checking bench for sfc_frame_check, ascii and binary framing.
 assumes the master model drives bytes; expectations come from local models.
*/
`timescale 1ns/1ps
module serial_frame_check_lrc_crc_tb;
	logic i_clk_sys = 1'b0;
	logic i_rst = 1'b1;
	logic i_ascii_mode = 1'b1;
	logic rx_valid;
	logic [7:0] rx_data;
	logic o_rx_done;
	logic o_frame_ok;
	logic o_check_err;
	logic [7:0] o_station;
	logic [7:0] o_function;
	logic o_too_many_words;
	int n_mismatch = 0;
	int checks = 0;
	int n_done = 0;
	int cyc = 0;
	logic [7:0] q[$];
	logic [15:0] crc_v;
	// gap scaled down from 10 ms so the whole run stays short
	localparam int GAP = 1001;
	always #50 i_clk_sys = ~i_clk_sys;
	sfc_master_model master (.i_clk_sys(i_clk_sys), .o_rx_valid(rx_valid), .o_rx_data(rx_data));
	sfc_frame_check #(.GAP_CYCLES(GAP)) DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.i_ascii_mode(i_ascii_mode),
		.i_rx_valid(rx_valid), .i_rx_data(rx_data), .o_rx_done(o_rx_done),
		.o_frame_ok(o_frame_ok), .o_check_err(o_check_err), .o_station(o_station),
		.o_function(o_function), .o_too_many_words(o_too_many_words));
	// ====================
	// reference models
	function automatic logic [7:0] lrc_of(input logic [7:0] b[$]);
		int s = 0;
		foreach (b[i]) s += b[i];
		return 8'((256 - s % 256) % 256);
	endfunction
	function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
		int c = 32'h0000ffff;
		foreach (b[i])
		begin
			c ^= b[i];
			repeat (8) c = (c & 1) ? ((c >> 1) ^ 32'h0000a001) : (c >> 1);
		end
		return 16'(c);
	endfunction
	// ====================
	// compares and verdict
	task automatic cmp_flag(input logic got, input logic exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// exp 2 only waits for the verdict pulse
	task automatic verdict(input int exp, input int lim);
		for (int n = 0; n < lim; n++)
		begin
			@(negedge i_clk_sys);
			if (o_frame_ok === 1'b1 || o_check_err === 1'b1)
				break;
		end
		if (exp != 2)
		begin
			cmp_flag(o_frame_ok, exp == 1);
			cmp_flag(o_check_err, exp == 0);
		end
		if (exp == 1)
		begin
			cmp_val({8'h00, o_station}, {8'h00, q[0]});
			cmp_val({8'h00, o_function}, {8'h00, q[1]});
		end
	endtask
	task automatic ascii_frame(input logic [7:0] bad, input int exp);
		q.push_back(lrc_of(q) ^ bad);
		master.send_ascii(q);
		verdict(exp, 20);
	endtask
	task automatic rand_q(input int n);
		q = {};
		repeat (n) q.push_back(8'($urandom));
		// keep random frames clear of the write-multiple word limit
		if (q.size() > 1 && q[1] == sfc_pkg::FC_WRITE_MULTI)
			q[1] = 8'h03;
	endtask
	task automatic tally_and_finish;
		if (n_mismatch == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge i_clk_sys)
	begin
		if (o_rx_done === 1'b1)
			n_done++;
		cyc++;
		// three binary gaps of GAP cycles dominate the run
		if (cyc == 20000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	// ====================
	// main sequence
	initial
	begin
		void'($urandom(32'h4226));
		repeat (10) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		q = '{8'h01, 8'h03, 8'h02, 8'h00, 8'h00, 8'h02};
		ascii_frame(8'h00, 1);
		master.send(sfc_pkg::COLON_CODE, 1);
		master.send(8'h37, 1);
		q = '{8'h7f, 8'h03, 8'h05, 8'hc4, 8'h00, 8'h01};
		ascii_frame(8'h00, 1);
		for (int k = 0; k < 6; k++)
		begin
			rand_q(3 + k);
			ascii_frame(8'h00, 1);
			rand_q(4 + k);
			ascii_frame(8'h01 << k, 0);
		end
		for (int w = 10; w < 12; w++)
		begin
			q = '{8'h01, sfc_pkg::FC_WRITE_MULTI, 8'h01, 8'h12, 8'h00, 8'(w), 8'(2 * w)};
			repeat (2 * w) q.push_back(8'($urandom));
			ascii_frame(8'h00, (w > 10) ? 0 : 1);
			cmp_flag(o_too_many_words, w > 10);
		end
		@(posedge i_clk_sys);
		i_ascii_mode <= 1'b0;
		repeat (GAP + 9) @(posedge i_clk_sys);
		q = '{8'h01, 8'h03, 8'h02, 8'h00, 8'h00, 8'h02};
		crc_v = crc_of(q);
		cmp_val(crc_v, 16'hb3c5);
		q.push_back(crc_v[7:0]);
		q.push_back(crc_v[15:8]);
		master.send_rtu(q);
		verdict(1, GAP + 100);
		// equal check bytes would make the swapped order look right
		do
		begin
			rand_q(6);
			crc_v = crc_of(q);
		end
		while (crc_v[15:8] == crc_v[7:0]);
		q.push_back(crc_v[15:8]);
		q.push_back(crc_v[7:0]);
		master.send_rtu(q);
		verdict(0, GAP + 100);
		cmp_val(16'(n_done), 16'(master.n_sent));
		tally_and_finish();
	end
endmodule
